// >>> design/sram_host.sv
// host controller that drives an asynchronous 16-bit static ram by its pins
// assumes the ram pins are wired direct; data and error flag are sampled twice
// requests are single words; a read answers with one pulse, a write only frees ready again
// assumes the requester holds a request until it sees ready high at a rising edge
//
// Functional notes
// - controller times data setup and hold to the ending edge.
// - strobe write pulse at least turn-off time plus data setup time.
// - controller never drives data while ram drives the lines.
// - write strobe stays high for the whole read cycle.
// - address valid no later than select falling edge.
`timescale 1ns/100ps
module sram_host
  import sram_host_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic req_valid_i,
  input wire logic req_write_i,
  input wire logic [ADDR_W-1:0] req_addr_i,
  input wire logic [DATA_W-1:0] req_wdata_i,
  input wire logic [LANES-1:0] req_lanes_i,
  output logic req_ready_o,
  output logic rsp_valid_o,
  output logic [DATA_W-1:0] rsp_rdata_o,
  output logic rsp_corrected_o,
  output logic [ADDR_W-1:0] addr_o,
  output logic chip_select_n_o,
  output logic output_drive_n_o,
  output logic write_strobe_n_o,
  output logic low_lane_select_n_o,
  output logic high_lane_select_n_o,
  input wire logic [DATA_W-1:0] data_i,
  output logic [DATA_W-1:0] data_o,
  output logic [DATA_W-1:0] data_oe_o,
  input wire logic err_i
);
  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    host_state_t st;
    logic [3:0] cnt;
    logic ready;
    logic rsp_valid;
    logic [DATA_W-1:0] rdata;
    logic corrected;
    logic [ADDR_W-1:0] addr;
    logic cs_n;
    logic oe_n;
    logic we_n;
    logic [LANES-1:0] lane_n;
    logic [DATA_W-1:0] dout;
    logic [DATA_W-1:0] doe;
    logic [DATA_W-1:0] din_s1;
    logic [DATA_W-1:0] din_s2;
    logic err_s1;
    logic err_s2;
  } host_regs_t;

  host_regs_t r;
  host_regs_t next_r;

  // every pin parks at its idle level, so the ram sits deselected through reset
  localparam host_regs_t RESET_REGS = '{
    st: ST_IDLE,
    cnt: CNT_ZERO,
    ready: 1'b0,
    rsp_valid: 1'b0,
    rdata: '0,
    corrected: 1'b0,
    addr: '0,
    cs_n: 1'b1,
    oe_n: 1'b1,
    we_n: 1'b1,
    lane_n: '1,
    dout: '0,
    doe: '0,
    din_s1: '0,
    din_s2: '0,
    err_s1: 1'b0,
    err_s2: 1'b0
  };

  // ****************************************
  // request decode and lane masks
  // ****************************************
  logic take;
  logic [DATA_W-1:0] req_mask;
  logic [DATA_W-1:0] sel_mask;

  // a request with no lane would strobe the ram without storing, so it is refused
  assign take = r.ready && req_valid_i && (req_lanes_i != '0);

  // one byte of mask per lane select
  for (genvar g = 0; g < LANES; g++)
  begin : g_lane
    assign req_mask[g*LANE_W +: LANE_W] = {LANE_W{req_lanes_i[g]}};
    assign sel_mask[g*LANE_W +: LANE_W] = {LANE_W{~r.lane_n[g]}};
  end

  // ****************************************
  // next state
  // ****************************************
  always_comb
  begin
    next_r = r;
    // ram lines change off our clock, so only the second flop is ever read
    next_r.din_s1 = data_i;
    next_r.din_s2 = r.din_s1;
    next_r.err_s1 = err_i;
    next_r.err_s2 = r.err_s1;
    next_r.rsp_valid = 1'b0;
    unique case (r.st)
      ST_IDLE:
      begin
        // stays ready while idle; a take drops it until the bus is parked again
        next_r.ready = 1'b1;
        if (take)
        begin
          next_r.ready = 1'b0;
          // address is set in the same edge select falls, never later
          next_r.addr = req_addr_i;
          next_r.cs_n = 1'b0;
          next_r.lane_n = ~req_lanes_i;
          if (req_write_i)
          begin
            // output drive held high so the ram never drives during a write
            next_r.oe_n = 1'b1;
            next_r.we_n = 1'b0;
            next_r.dout = req_wdata_i;
            next_r.doe = req_mask;
            next_r.cnt = WRITE_CYC;
            next_r.st = ST_WRITE;
          end
          else
          begin
            // output drive falls with select; the address is steady from the same edge
            next_r.oe_n = 1'b0;
            next_r.we_n = 1'b1;
            next_r.doe = '0;
            next_r.cnt = READ_CYC;
            next_r.st = ST_READ;
          end
        end
      end

      ST_READ:
      begin
        // select and output drive stay low for the whole count, strobe high
        next_r.cnt = r.cnt - CNT_ONE;
        if (r.cnt == CNT_ONE)
        begin
          // the sampled word left the ram two edges back, well past its access time
          next_r.rdata = r.din_s2 & sel_mask;
          next_r.corrected = r.err_s2;
          next_r.rsp_valid = 1'b1;
          next_r.oe_n = 1'b1;
          next_r.cs_n = 1'b1;
          next_r.lane_n = '1;
          next_r.st = ST_RECOVER;
        end
      end

      ST_WRITE:
      begin
        next_r.cnt = r.cnt - CNT_ONE;
        if (r.cnt == CNT_ONE)
        begin
          // strobe alone ends the write; data and select hold one more cycle
          next_r.we_n = 1'b1;
          next_r.st = ST_RECOVER;
        end
      end

      ST_RECOVER:
      begin
        // data hold past the ending edge, then release every line
        next_r.doe = '0;
        next_r.cs_n = 1'b1;
        next_r.lane_n = '1;
        next_r.ready = 1'b1;
        next_r.st = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      r <= RESET_REGS;
    end
    else
    begin
      r <= next_r;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  // pins come straight from registers, so no decode glitch ever reaches the ram
  assign req_ready_o = r.ready;
  assign rsp_valid_o = r.rsp_valid;
  assign rsp_rdata_o = r.rdata;
  assign rsp_corrected_o = r.corrected;
  assign addr_o = r.addr;
  assign chip_select_n_o = r.cs_n;
  assign output_drive_n_o = r.oe_n;
  assign write_strobe_n_o = r.we_n;
  assign low_lane_select_n_o = r.lane_n[0];
  assign high_lane_select_n_o = r.lane_n[1];
  assign data_o = r.dout;
  assign data_oe_o = r.doe;
endmodule : sram_host

// >>> design/sram_host_pkg.sv
// constants for the host-side controller of a 16-bit asynchronous static ram
// assumes a 100 mhz clock; times are in nanoseconds as printed
package sram_host_pkg;
  localparam int ADDR_W = 20;
  localparam int DATA_W = 16;
  localparam int LANE_W = 8;
  localparam int LANES = 2;
  localparam int CLK_NS = 10;
  // ****************************************
  // timing
  // ****************************************
  localparam int STROBE_TO_FLOAT_TIME = 5;
  localparam int WRITE_DATA_SETUP_TIME = 5;
  localparam int WRITE_PULSE_MIN_NS = 7;
  localparam int READ_ACCESS_NS = 10;
  // least times round up, never below one cycle
  localparam int PULSE_NS_MAX = (STROBE_TO_FLOAT_TIME + WRITE_DATA_SETUP_TIME >
    WRITE_PULSE_MIN_NS) ? STROBE_TO_FLOAT_TIME + WRITE_DATA_SETUP_TIME : WRITE_PULSE_MIN_NS;
  localparam int WRITE_CYC_I = (PULSE_NS_MAX + CLK_NS - 1) / CLK_NS;
  localparam int READ_CYC_I = (READ_ACCESS_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [3:0] WRITE_CYC = 4'(WRITE_CYC_I < 1 ? 1 : WRITE_CYC_I);
  // three extra cycles cover output turn-on plus the two-flop input sampling
  localparam logic [3:0] READ_CYC = 4'((READ_CYC_I < 1 ? 1 : READ_CYC_I) + 3);
  localparam logic [3:0] CNT_ZERO = 4'h0;
  localparam logic [3:0] CNT_ONE = 4'h1;
  typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_WRITE, ST_RECOVER} host_state_t;
endpackage : sram_host_pkg

// >>> verif/sram_host_chk.sv
// assertions on the ports of the static ram host controller
// bound into every sram_host instance
`timescale 1ns/100ps
module sram_host_chk
  import sram_host_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic req_valid_i,
  input wire logic req_write_i,
  input wire logic [LANES-1:0] req_lanes_i,
  input wire logic req_ready_o,
  input wire logic rsp_valid_o,
  input wire logic [ADDR_W-1:0] addr_o,
  input wire logic chip_select_n_o,
  input wire logic output_drive_n_o,
  input wire logic write_strobe_n_o,
  input wire logic low_lane_select_n_o,
  input wire logic high_lane_select_n_o,
  input wire logic [DATA_W-1:0] data_o,
  input wire logic [DATA_W-1:0] data_oe_o
);
  wire take = req_ready_o && req_valid_i && req_lanes_i != 2'h0;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  AST_READ_STROBE_HIGH: assert property (!output_drive_n_o |-> write_strobe_n_o)
    else $error("strobe low in read");
  AST_NO_CLASH: assert property (!output_drive_n_o |-> data_oe_o == '0)
    else $error("host drives during read");
  AST_ADDR_HELD: assert property (!chip_select_n_o && $past(!chip_select_n_o) |-> $stable(addr_o))
    else $error("address moved while selected");
  AST_DATA_HOLD: assert property ($rose(write_strobe_n_o) && !chip_select_n_o |->
    $stable(data_o) && data_oe_o != '0) else $error("data not held past strobe");
  AST_STROBE_ENDS: assert property ($fell(write_strobe_n_o) |=> write_strobe_n_o &&
    !chip_select_n_o) else $error("strobe does not end the write");
  AST_WRITE_QUAL: assert property (!write_strobe_n_o |-> !chip_select_n_o &&
    !(low_lane_select_n_o && high_lane_select_n_o)) else $error("strobe without select");
  AST_WRITE_TURN: assert property (take && req_write_i |=> !req_ready_o [*2] ##1 req_ready_o)
    else $error("write turnaround");
  AST_READ_RSP: assert property (take && !req_write_i |=> !rsp_valid_o [*4] ##1 rsp_valid_o)
    else $error("read answer timing");
  AST_LANE_MAP: assert property (take |=> low_lane_select_n_o == !$past(req_lanes_i[0]))
    else $error("low lane select wrong");
endmodule : sram_host_chk
bind sram_host sram_host_chk i_chk (.clk_i(clk_i), .rst_i(rst_i), .req_valid_i(req_valid_i),
  .req_write_i(req_write_i), .req_lanes_i(req_lanes_i), .req_ready_o(req_ready_o),
  .rsp_valid_o(rsp_valid_o), .addr_o(addr_o), .chip_select_n_o(chip_select_n_o),
  .output_drive_n_o(output_drive_n_o), .write_strobe_n_o(write_strobe_n_o),
  .low_lane_select_n_o(low_lane_select_n_o), .high_lane_select_n_o(high_lane_select_n_o),
  .data_o(data_o), .data_oe_o(data_oe_o));

// >>> verif/sram_model.sv
// behavioural 16-bit asynchronous static ram, 16 words, with byte lanes and error flag
// no clock; the bench merges its lines with the host's; odd addresses report a correction
`timescale 1ns/100ps
module sram_model
  import sram_host_pkg::*;
(
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic chip_select_n_i,
  input wire logic output_drive_n_i,
  input wire logic write_strobe_n_i,
  input wire logic low_lane_select_n_i,
  input wire logic high_lane_select_n_i,
  input wire logic [DATA_W-1:0] data_i,
  output logic [DATA_W-1:0] data_o,
  output logic err_o
);
  logic [DATA_W-1:0] mem [16];
  logic [DATA_W-1:0] last = 16'h5a5a;
  wire [1:0] lane = ~{high_lane_select_n_i, low_lane_select_n_i};
  wire [DATA_W-1:0] m = {{8{lane[1]}}, {8{lane[0]}}};
  wire rd = !chip_select_n_i && !output_drive_n_i && write_strobe_n_i;
  wire wr = !chip_select_n_i && !write_strobe_n_i && lane != 2'h0;
  logic [DATA_W-1:0] wd;
  logic [3:0] wa;
  logic [1:0] wl;
  // the word is stored as the write ends, so lines settling one by one never store
  always_latch
  begin
    if (wr)
    begin
      wa = addr_i[3:0];
      wd = data_i;
      wl = lane;
    end
  end
  always @(negedge wr)
  begin
    if (wl[0]) mem[wa][7:0] = wd[7:0];
    if (wl[1]) mem[wa][15:8] = wd[15:8];
  end
  // floating lines show the inverse of the last value so stale data never reads right
  always @(negedge rd) last <= mem[addr_i[3:0]];
  assign data_o = rd ? (mem[addr_i[3:0]] & m) | (~last & ~m) : ~last;
  assign err_o = rd ? addr_i[0] : ~last[0];
endmodule : sram_model

// >>> verif/testbench.sv
// self-checking bench for the static ram host controller
// drives the request side, the ram model answers on the pins
`timescale 1ns/100ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin err_count++; \
  $display("mismatch %0t %h %h", $time, a, b); end end
module testbench;
  import sram_host_pkg::*;
  logic clk_i = 0, rst_i = 1, rv = 0, rw = 0, cs, oe, we, ll, hl, rdy, vld, cor, err;
  logic [ADDR_W-1:0] ra = '0, ma;
  logic [DATA_W-1:0] rd = '0, hd, hoe, md, q, ref_mem [16];
  logic [1:0] rl = '0;
  int err_count = 0, total_checks = 0;
  wire [DATA_W-1:0] bus = (hoe & hd) | (~hoe & md);
  sram_host i_sram_host (.clk_i(clk_i), .rst_i(rst_i), .req_valid_i(rv), .req_write_i(rw),
    .req_addr_i(ra), .req_wdata_i(rd), .req_lanes_i(rl), .req_ready_o(rdy), .rsp_valid_o(vld),
    .rsp_rdata_o(q), .rsp_corrected_o(cor), .addr_o(ma), .chip_select_n_o(cs),
    .output_drive_n_o(oe), .write_strobe_n_o(we), .low_lane_select_n_o(ll),
    .high_lane_select_n_o(hl), .data_i(bus), .data_o(hd), .data_oe_o(hoe), .err_i(err));
  sram_model i_sram_model (.addr_i(ma), .chip_select_n_i(cs), .output_drive_n_i(oe),
    .write_strobe_n_i(we), .low_lane_select_n_i(ll), .high_lane_select_n_i(hl),
    .data_i(bus), .data_o(md), .err_o(err));
  function automatic logic [15:0] mask(input logic [1:0] l);
    return {{8{l[1]}}, {8{l[0]}}};
  endfunction : mask
  task automatic op(input logic w, input logic [3:0] a, input logic [15:0] d, input logic [1:0] l);
    @(posedge clk_i);
    rv <= 1'b1;
    rw <= w;
    ra <= {16'h0, a};
    rd <= d;
    rl <= l;
    do @(negedge clk_i); while (rdy !== 1'b1);
    @(posedge clk_i);
    rv <= 1'b0;
    if (w) ref_mem[a] = (ref_mem[a] & ~mask(l)) | (d & mask(l));
    else
    begin
      for (int i = 0; i < 9 && vld !== 1'b1; i++) @(negedge clk_i);
      `CHK(vld, 1'b1)
      `CHK(q, ref_mem[a] & mask(l))
      `CHK(cor, a[0])
    end
  endtask : op
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : stop_test
  initial forever #5 clk_i = ~clk_i;
  initial
  begin
    #100000;
    err_count++;
    stop_test();
  end
  initial
  begin
    void'($urandom(84072));
    repeat (7) @(posedge clk_i);
    @(negedge clk_i);
    // during reset: nothing taken, nothing driven, every strobe parked high
    `CHK({rdy, vld, hoe}, 18'h0)
    `CHK({cs, oe, we, ll, hl}, 5'h1f)
    @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 16; i++) op(1'b1, 4'(i), 16'($urandom), 2'h3);
    // lanes of zero are ignored, so the word must read back unchanged
    op(1'b1, 4'h5, 16'h0000, 2'h0);
    op(1'b0, 4'h5, 16'h0, 2'h3);
    op(1'b1, 4'h2, 16'hffff, 2'h1);
    op(1'b1, 4'h3, 16'h0000, 2'h2);
    for (int l = 1; l < 4; l++) op(1'b0, 4'h2, 16'h0, 2'(l));
    $display("corner test done");
    repeat (60) op(1'($urandom), 4'($urandom), 16'($urandom), 2'($urandom_range(1, 3)));
    $display("random test done");
    stop_test();
  end
endmodule : testbench
